// ---- shared/ctp_cfg.svh ----
`ifndef CTP_CFG_SVH
`define CTP_CFG_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define CTP_ADDR_ALLOW_MAIN 8'h0A
`define CTP_ADDR_TUNE_HIGH 8'h0B
`define CTP_ADDR_TUNE_MID 8'h0C
`define CTP_ADDR_TUNE_LOW 8'h0D
`define CTP_ADDR_DEV_STEP 8'h0E
`define CTP_ADDR_SHAPED_STEP 8'h0F
`define CTP_ADDR_ALLOW_ALIAS 8'h10
`define CTP_ADDR_LEN_HIGH 8'h11
`define CTP_ADDR_LEN_LOW 8'h12
`define CTP_ADDR_TX_DATA 8'h13
`define CTP_ADDR_SENT_HIGH 8'h14
`define CTP_ADDR_SENT_LOW 8'h15
`define CTP_ADDR_FIFO_STAT 8'h16

// ****************************************************************
// field positions
// ****************************************************************
`define CTP_ALLOW_BIT 2
`define CTP_LEN_MODE_BIT 7
`define CTP_DONE_BIT 7

// ****************************************************************
// reset values
// ****************************************************************
`define CTP_RST_TUNE_HIGH 8'h13
`define CTP_RST_TUNE_MID 8'hB0
`define CTP_RST_TUNE_LOW 8'h00
`define CTP_RST_DEV_STEP 7'h28
`define CTP_RST_SHAPED_STEP 4'h4
`define CTP_RST_LEN_HIGH 8'h00
`define CTP_RST_LEN_LOW 8'hFF

// ****************************************************************
// timing
// ****************************************************************
`define CTP_CLK_PERIOD_NS 10
`define CTP_BIT_TIME_NS 5000
`define CTP_BIT_CYCLES (`CTP_BIT_TIME_NS / `CTP_CLK_PERIOD_NS)

`endif

// ---- shared/ctp_pkg.sv ----
package ctp_pkg;

   // ****************************************************************
   // transmit sequencer states
   // ****************************************************************
   typedef enum logic [0:0] {
      st_idle,
      st_send
   } ctp_state_type;

   // ****************************************************************
   // whole state of the register bank
   // ****************************************************************
   typedef struct packed {
      logic [23:0] tuning_word;    // carrier tuning word
      logic [6:0] dev_step;        // plain keying deviation step
      logic [3:0] shaped_step;     // shaped keying deviation step
      logic tx_allow;              // serial transmit allow (aliased)
      logic len_mode;              // length limit select
      logic [14:0] frame_len;      // frame bit count
      logic [7:0] tx_data_last;    // last byte written to data reg
      logic [7:0][7:0] fifo_mem;   // transmit fifo storage
      logic [2:0] wr_ptr;          // fifo write pointer
      logic [2:0] rd_ptr;          // fifo read pointer
      logic [3:0] fifo_cnt;        // fifo fill level 0..8
      logic uflow;                 // sticky underflow
      logic oflow;                 // sticky overflow
      logic done;                  // frame done flag
      logic [14:0] sent;           // bits sent in current frame
      ctp_state_type state;        // sequencer state
      logic [7:0] shift;           // outgoing byte
      logic [3:0] bits_left;       // bits left in shift
      logic [8:0] tick_cnt;        // bit rate divider
      logic tx_bit;                // serial data to modulator
      logic tx_active;             // frame in progress
      logic [6:0] dev_word;        // active deviation step
      logic dev_shaped;            // deviation uses shaped scale
      logic [7:0] rdata;           // read data
   } ctp_state_s_type;

endpackage : ctp_pkg

// ---- design/ctp_carrier_packet_regs.sv ----
// What this block does
// - lo frequency is tuning word/2^16 times crystal
// - unshaped fsk deviation is step times crystal/8192
// - shaped fsk deviation is step times crystal/81920
// - bit 2 of 0x10 aliases transmit allow
// - length select 0: underflow ends the frame
// - length select 1: end at count or underflow
// - 0x11 holds count high bits and select
// - data register writes push into transmit fifo
// - read-only flag shows frame transmission completed
`timescale 1ns/10ps
`include "ctp_cfg.svh"

module ctp_carrier_packet_regs (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // register access from the serial bus front end
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_ff,
   // modulation controls held in other registers
   input wire logic modulation_select,
   input wire logic shaped_keying_select,
   // synthesiser controls
   output logic [23:0] carrier_tuning_word_ff,
   output logic [6:0] deviation_word_ff,
   output logic deviation_shaped_ff,
   // serial data to the modulator
   output logic tx_bit_ff,
   output logic tx_active_ff,
   output logic frame_done_flag_ff
);
   import ctp_pkg::*;

   // registered state and its next value
   ctp_state_s_type st_ff;
   ctp_state_s_type nxt_st;

   // last count of the bit period, at the width of the divider
   localparam logic [8:0] BIT_LAST = 9'(`CTP_BIT_CYCLES - 1);
   // reset byte of the count high register, split into its fields
   localparam logic [7:0] RST_LEN_HIGH = `CTP_RST_LEN_HIGH;

   // ****************************************************************
   // read decode
   // ****************************************************************
   function automatic logic [7:0] read_mux(input ctp_state_s_type s,
                                          input logic [7:0] a);
      logic [7:0] d;
      d = 8'h00;
      case (a)
         `CTP_ADDR_TUNE_HIGH: d = s.tuning_word[23:16];
         `CTP_ADDR_TUNE_MID: d = s.tuning_word[15:8];
         `CTP_ADDR_TUNE_LOW: d = s.tuning_word[7:0];
         `CTP_ADDR_DEV_STEP: d = {1'b0, s.dev_step};
         `CTP_ADDR_SHAPED_STEP: d = {4'h0, s.shaped_step};
         // both addresses show the single allow bit
         `CTP_ADDR_ALLOW_MAIN,
         `CTP_ADDR_ALLOW_ALIAS: d[`CTP_ALLOW_BIT] = s.tx_allow;
         `CTP_ADDR_LEN_HIGH: d = {s.len_mode, s.frame_len[14:8]};
         `CTP_ADDR_LEN_LOW: d = s.frame_len[7:0];
         `CTP_ADDR_TX_DATA: d = s.tx_data_last;
         `CTP_ADDR_SENT_HIGH: d = {s.done, s.sent[14:8]};
         `CTP_ADDR_SENT_LOW: d = s.sent[7:0];
         `CTP_ADDR_FIFO_STAT: d = {s.uflow, s.oflow,
                                   (s.fifo_cnt == 4'h0),
                                   s.fifo_cnt[3], 1'b0,
                                   s.fifo_cnt[2:0]};
         default: d = 8'h00;
      endcase
      return d;
   endfunction : read_mux

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      // per-cycle strobes, all cleared first
      logic push;
      logic pop;
      logic fifo_empty;
      logic fifo_full;
      logic set_uflow;
      logic set_oflow;
      logic end_frame;
      push = 1'b0;
      pop = 1'b0;
      set_uflow = 1'b0;
      set_oflow = 1'b0;
      end_frame = 1'b0;
      // defaults: every register holds its value
      nxt_st = st_ff;
      // fifo level decode for this cycle
      fifo_empty = (st_ff.fifo_cnt == 4'h0);
      fifo_full = st_ff.fifo_cnt[3];

      // ****************************************************************
      // register writes
      // ****************************************************************
      if (reg_wr) begin
         case (reg_addr)
            // tuning word bytes, high to low
            `CTP_ADDR_TUNE_HIGH: nxt_st.tuning_word[23:16] = reg_wdata;
            `CTP_ADDR_TUNE_MID: nxt_st.tuning_word[15:8] = reg_wdata;
            `CTP_ADDR_TUNE_LOW: nxt_st.tuning_word[7:0] = reg_wdata;
            // deviation steps, unused upper bits dropped
            `CTP_ADDR_DEV_STEP: nxt_st.dev_step = reg_wdata[6:0];
            `CTP_ADDR_SHAPED_STEP: nxt_st.shaped_step = reg_wdata[3:0];
            // either address writes the same allow bit
            `CTP_ADDR_ALLOW_MAIN,
            `CTP_ADDR_ALLOW_ALIAS: begin
               nxt_st.tx_allow = reg_wdata[`CTP_ALLOW_BIT];
            end
            `CTP_ADDR_LEN_HIGH: begin
               nxt_st.len_mode = reg_wdata[`CTP_LEN_MODE_BIT];
               nxt_st.frame_len[14:8] = reg_wdata[6:0];
            end
            // frame count low byte
            `CTP_ADDR_LEN_LOW: nxt_st.frame_len[7:0] = reg_wdata;
            // data bytes go to the fifo, dropped when full
            `CTP_ADDR_TX_DATA: begin
               nxt_st.tx_data_last = reg_wdata;
               if (fifo_full) begin
                  set_oflow = 1'b1;
               end else begin
                  push = 1'b1;
               end
            end
            default: begin
               // read-only or unmapped: ignored
            end
         endcase
      end

      // ****************************************************************
      // reading fifo status clears the sticky error bits
      // ****************************************************************
      if (reg_rd && (reg_addr == `CTP_ADDR_FIFO_STAT)) begin
         nxt_st.uflow = 1'b0;
         nxt_st.oflow = 1'b0;
      end

      // ****************************************************************
      // bit rate divider, runs only during a frame
      // ****************************************************************
      if (st_ff.state == st_send && st_ff.tick_cnt != BIT_LAST) begin
         // count up to the end of the bit period
         nxt_st.tick_cnt = st_ff.tick_cnt + 9'h001;
      end else begin
         // idle or period end: restart
         nxt_st.tick_cnt = 9'h000;
      end

      // ****************************************************************
      // transmit sequencer
      // ****************************************************************
      case (st_ff.state)
         // start a frame when allowed and data is waiting
         st_idle: begin
            if (st_ff.tx_allow && !fifo_empty) begin
               // load the first byte, clear frame status
               pop = 1'b1;
               nxt_st.shift = st_ff.fifo_mem[st_ff.rd_ptr];
               nxt_st.bits_left = 4'h8;
               nxt_st.sent = 15'h0000;
               nxt_st.done = 1'b0;
               nxt_st.tx_active = 1'b1;
               nxt_st.state = st_send;
            end
         end
         // one bit per bit period, msb first
         st_send: begin
            if (st_ff.tick_cnt == BIT_LAST) begin
               // shift out the msb, count the bit
               nxt_st.tx_bit = st_ff.shift[7];
               nxt_st.shift = {st_ff.shift[6:0], 1'b0};
               nxt_st.bits_left = st_ff.bits_left - 4'h1;
               nxt_st.sent = st_ff.sent + 15'h0001;
               if (st_ff.len_mode &&
                   (st_ff.sent + 15'h0001 >= st_ff.frame_len)) begin
                  end_frame = 1'b1;
               end else if (st_ff.bits_left == 4'h1) begin
                  // byte boundary: stop, end or fetch next
                  if (!st_ff.tx_allow) begin
                     // allow cleared: stop at the byte boundary
                     nxt_st.state = st_idle;
                     nxt_st.tx_active = 1'b0;
                  end else if (fifo_empty) begin
                     set_uflow = 1'b1;
                     end_frame = 1'b1;
                  end else begin
                     // next byte follows with no gap
                     pop = 1'b1;
                     nxt_st.shift = st_ff.fifo_mem[st_ff.rd_ptr];
                     nxt_st.bits_left = 4'h8;
                  end
               end
            end
         end
         default: begin
            nxt_st.state = st_idle;
         end
      endcase

      // ****************************************************************
      // frame end marks completion for the host
      // ****************************************************************
      if (end_frame) begin
         nxt_st.done = 1'b1;
         nxt_st.state = st_idle;
         nxt_st.tx_active = 1'b0;
      end

      // ****************************************************************
      // sticky errors: a new event beats the read clear
      // ****************************************************************
      if (set_uflow) begin
         // fifo ran dry at a byte boundary
         nxt_st.uflow = 1'b1;
      end
      if (set_oflow) begin
         // data byte dropped on a full fifo
         nxt_st.oflow = 1'b1;
      end

      // ****************************************************************
      // fifo pointers and level
      // ****************************************************************
      if (push) begin
         // write side: store and advance
         nxt_st.fifo_mem[st_ff.wr_ptr] = reg_wdata;
         nxt_st.wr_ptr = st_ff.wr_ptr + 3'h1;
      end
      if (pop) begin
         // read side: advance past the taken byte
         nxt_st.rd_ptr = st_ff.rd_ptr + 3'h1;
      end
      nxt_st.fifo_cnt = st_ff.fifo_cnt + {3'h0, push} - {3'h0, pop};

      // ****************************************************************
      // deviation step and scale to the synthesiser
      // ****************************************************************
      if (!modulation_select) begin
         // amplitude keying: no deviation
         nxt_st.dev_word = 7'h00;
         nxt_st.dev_shaped = 1'b0;
      end else if (shaped_keying_select) begin
         // shaped keying: coarse 4-bit step
         nxt_st.dev_word = {3'h0, st_ff.shaped_step};
         nxt_st.dev_shaped = 1'b1;
      end else begin
         // plain keying: full 7-bit step
         nxt_st.dev_word = st_ff.dev_step;
         nxt_st.dev_shaped = 1'b0;
      end

      // ****************************************************************
      // registered read data
      // ****************************************************************
      if (reg_rd) begin
         // only a read strobe refreshes the byte
         nxt_st.rdata = read_mux(st_ff, reg_addr);
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         // clear everything, then load the documented values
         st_ff <= '0;
         st_ff.tuning_word <= {`CTP_RST_TUNE_HIGH, `CTP_RST_TUNE_MID,
                               `CTP_RST_TUNE_LOW};
         st_ff.dev_step <= `CTP_RST_DEV_STEP;
         st_ff.shaped_step <= `CTP_RST_SHAPED_STEP;
         // mode select and count high bits share one byte
         st_ff.len_mode <= RST_LEN_HIGH[`CTP_LEN_MODE_BIT];
         st_ff.frame_len <= {RST_LEN_HIGH[6:0], `CTP_RST_LEN_LOW};
         st_ff.state <= st_idle;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ****************************************************************
   // outputs straight from the state register
   // ****************************************************************
   assign reg_rdata_ff = st_ff.rdata;
   assign carrier_tuning_word_ff = st_ff.tuning_word;
   assign deviation_word_ff = st_ff.dev_word;
   assign deviation_shaped_ff = st_ff.dev_shaped;
   assign tx_bit_ff = st_ff.tx_bit;
   assign tx_active_ff = st_ff.tx_active;
   assign frame_done_flag_ff = st_ff.done;

endmodule : ctp_carrier_packet_regs

// ---- verif/ctp_regs_chk.sv ----
`timescale 1ns/10ps
// ****************************************************************
// port checker
// ****************************************************************
module ctp_regs_chk (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata_ff,
   // modulation and outputs
   input wire logic modulation_select,
   input wire logic shaped_keying_select,
   input wire logic [23:0] carrier_tuning_word_ff,
   input wire logic [6:0] deviation_word_ff,
   input wire logic deviation_shaped_ff,
   input wire logic tx_bit_ff,
   input wire logic tx_active_ff,
   input wire logic frame_done_flag_ff
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // frame boundaries
   sequence frame_go; $rose(tx_active_ff); endsequence
   sequence frame_end; $fell(tx_active_ff); endsequence
   tune_high_a: assert property (
      reg_wr && reg_addr == 8'h0B |=> carrier_tuning_word_ff[23:16] ==
      $past(reg_wdata)) else $error("tuning high byte not taken");
   tune_mid_a: assert property (
      reg_wr && reg_addr == 8'h0C |=> carrier_tuning_word_ff[15:8] ==
      $past(reg_wdata)) else $error("tuning mid byte not taken");
   tune_low_a: assert property (
      reg_wr && reg_addr == 8'h0D |=> carrier_tuning_word_ff[7:0] ==
      $past(reg_wdata)) else $error("tuning low byte not taken");
   word_hold_a: assert property (
      !reg_wr |=> $stable(carrier_tuning_word_ff))
      else $error("tuning word moved without a write");
   dev_plain_a: assert property (
      modulation_select && !shaped_keying_select |=> !deviation_shaped_ff)
      else $error("plain keying shows shaped scale");
   dev_shaped_a: assert property (
      modulation_select && shaped_keying_select |=> deviation_shaped_ff &&
      deviation_word_ff[6:4] == 3'h0) else $error("shaped step wrong");
   start_clear_a: assert property (
      frame_go |-> !frame_done_flag_ff) else $error("done high at start");
   done_end_a: assert property (
      $rose(frame_done_flag_ff) |-> frame_end)
      else $error("done rose outside frame end");
   frame_min_a: assert property (
      frame_go |=> tx_active_ff [*8]) else $error("frame ended too soon");
   read_done_a: assert property (
      reg_rd && reg_addr == 8'h14 |=> reg_rdata_ff[7] ==
      $past(frame_done_flag_ff)) else $error("done flag read wrong");
endmodule : ctp_regs_chk

bind ctp_carrier_packet_regs ctp_regs_chk i_chk (
   .clk_sys(clk_sys),
   .rst(rst),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_rdata_ff(reg_rdata_ff),
   .modulation_select(modulation_select),
   .shaped_keying_select(shaped_keying_select),
   .carrier_tuning_word_ff(carrier_tuning_word_ff),
   .deviation_word_ff(deviation_word_ff),
   .deviation_shaped_ff(deviation_shaped_ff),
   .tx_bit_ff(tx_bit_ff),
   .tx_active_ff(tx_active_ff),
   .frame_done_flag_ff(frame_done_flag_ff)
);

// ---- verif/ctp_tx_rx_model.sv ----
`timescale 1ns/10ps
// ****************************************************************
// modulator side: samples serial bits mid period, msb first
// ****************************************************************
module ctp_tx_rx_model (
   // inputs from the block
   input wire logic clk_sys,
   input wire logic tx_bit_ff,
   input wire logic tx_active_ff,
   // captured byte
   output logic [7:0] rx_byte
);
   initial begin
      rx_byte = 8'h00;
      forever begin
         @(posedge tx_active_ff);
         repeat (250) @(negedge clk_sys);
         // first bit lands 500 cycles after frame start
         for (int i = 7; i >= 0; i--) begin
            repeat (500) @(negedge clk_sys);
            rx_byte[i] = tx_bit_ff;
         end
      end
   end
endmodule : ctp_tx_rx_model

// ---- verif/tb_ctp_carrier_packet_regs.sv ----
`timescale 1ns/10ps
// ****************************************************************
// testbench
// ****************************************************************
module tb_ctp_carrier_packet_regs;
   logic clk_sys, rst, reg_wr, reg_rd, mod_sel, shp_sel;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_ff, rx_byte;
   logic [23:0] word;
   logic [6:0] dev;
   logic dev_shp, tx_bit, tx_act, done;
   int error_cnt = 0;
   int cmp_count = 0;
   ctp_carrier_packet_regs i_dut (.clk_sys(clk_sys), .rst(rst),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
      .modulation_select(mod_sel), .shaped_keying_select(shp_sel),
      .carrier_tuning_word_ff(word), .deviation_word_ff(dev),
      .deviation_shaped_ff(dev_shp), .tx_bit_ff(tx_bit),
      .tx_active_ff(tx_act), .frame_done_flag_ff(done));
   ctp_tx_rx_model i_rx (.clk_sys(clk_sys), .tx_bit_ff(tx_bit),
      .tx_active_ff(tx_act), .rx_byte(rx_byte));
   // clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // compare and count
   task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // one write strobe
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask : wr
   // one read strobe, data valid a cycle later
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_sys);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      chk($sformatf("reg %h", a), {16'h0000, reg_rdata_ff}, {16'h0000, exp});
   endtask : rd
   // wait for a frame to start and finish, then let the model finish
   task wait_end;
      for (int i = 0; i < 20 && tx_act !== 1'b1; i++) @(negedge clk_sys);
      chk("start", {23'h0, tx_act}, 24'h1);
      for (int i = 0; i < 9000 && tx_act !== 1'b0; i++) @(negedge clk_sys);
      chk("stop", {23'h0, tx_act}, 24'h0);
      chk("done", {23'h0, done}, 24'h1);
      repeat (2500) @(negedge clk_sys);
   endtask : wait_end
   // verdict
   task finish_test;
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finish_test
   // watchdog
   initial begin
      #500us;
      error_cnt++;
      finish_test();
   end
   // main sequence
   initial begin
      {rst, reg_wr, reg_rd, mod_sel, shp_sel} = 5'h10;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      repeat (16) @(negedge clk_sys);
      rst = 1'b0;
      chk("word", word, 24'h13B000);
      rd(8'h0B, 8'h13);
      rd(8'h0C, 8'hB0);
      rd(8'h0D, 8'h00);
      rd(8'h0E, 8'h28);
      rd(8'h0F, 8'h04);
      rd(8'h10, 8'h00);
      rd(8'h11, 8'h00);
      rd(8'h30, 8'h00);
      wr(8'h0B, 8'hA1);
      wr(8'h0C, 8'h5C);
      wr(8'h0D, 8'h3E);
      chk("word", word, 24'hA15C3E);
      rd(8'h0C, 8'h5C);
      // deviation steps with and without shaping
      wr(8'h0E, 8'hFF);
      wr(8'h0F, 8'hFA);
      mod_sel = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk("dev", {16'h0, dev_shp, dev}, 24'h7F);
      shp_sel = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk("dev", {16'h0, dev_shp, dev}, 24'h8A);
      mod_sel = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk("dev", {16'h0, dev_shp, dev}, 24'h0);
      // aliased allow bit
      wr(8'h0A, 8'h04);
      rd(8'h10, 8'h04);
      wr(8'h10, 8'h00);
      rd(8'h0A, 8'h00);
      // counted frame of four bits
      wr(8'h11, 8'h80);
      wr(8'h12, 8'h04);
      rd(8'h11, 8'h80);
      wr(8'h13, 8'hA5);
      wr(8'h10, 8'h04);
      wait_end();
      rd(8'h14, 8'h80);
      rd(8'h15, 8'h04);
      rd(8'h16, 8'h20);
      chk("rx", {20'h0, rx_byte[7:4]}, 24'hA);
      // unlimited frame ends on underflow, count ignored
      wr(8'h11, 8'h00);
      wr(8'h13, 8'h3C);
      wait_end();
      rd(8'h14, 8'h80);
      rd(8'h15, 8'h08);
      rd(8'h16, 8'hA0);
      rd(8'h16, 8'h20);
      chk("rx", {17'h0, rx_byte[7:1]}, 24'h1E);
      // allow cleared: a full fifo waits, the ninth byte is dropped
      wr(8'h10, 8'h00);
      for (int i = 0; i < 9; i++) wr(8'h13, 8'(i));
      chk("active", {23'h0, tx_act}, 24'h0);
      rd(8'h16, 8'h50);
      rd(8'h16, 8'h10);
      rd(8'h13, 8'h08);
      finish_test();
   end
endmodule : tb_ctp_carrier_packet_regs
